// [logic/cdp_consts.vh]
// Constants of the column drive phase control: command codes, field
// positions, reset values, level codes and the scan timing counts.
// Assumes it is included by bare name from the design files.
`ifndef CDP_CONSTS_VH
`define CDP_CONSTS_VH

// Command codes carried in the upper byte of a command word
`define CDP_ADDR_OVERRIDE 8'h1a
`define CDP_ADDR_PH1 8'h1b
`define CDP_ADDR_PH2 8'h1c

// Reset values of the configuration registers
`define CDP_RST_OVERRIDE 8'h00
`define CDP_RST_PH1 8'h0f
`define CDP_RST_PH2 8'h00

// Bit positions in the column output override register
`define CDP_BIT_POST_PWM_FLOAT 0
`define CDP_BIT_LINE_SYNC_FLOAT 1
`define CDP_BIT_ALL_FLOAT 2
`define CDP_BIT_ALL_HIGH 3

// Fields of the setup phase configuration registers
`define CDP_LEN_MSB 5
`define CDP_LEN_LSB 0
`define CDP_LVL_MSB 7
`define CDP_LVL_LSB 6

// Column level codes
`define CDP_LVL_LOW 2'h0
`define CDP_LVL_HIZ 2'h1
`define CDP_LVL_HIGH 2'h2
`define CDP_LVL_CURRENT 2'h3

// Scan phases within one row
`define CDP_PH_ONE 2'h0
`define CDP_PH_TWO 2'h1
`define CDP_PH_DRIVE 2'h2

// Timing counts: drive and sync in system clock cycles, and the number of rows
`define CDP_DRIVE_CYCLES 16
`define CDP_SYNC_CYCLES 1
`define CDP_ROWS 72

`endif

// [logic/cdp_column_cell.v]
// One column's level selection for the current scan phase.
// Assumes phase, configuration and gray data are already registered.
`timescale 1ns/100ps
`include "cdp_consts.vh"

module cdp_column_cell (
  input wire [1:0] i_phase,
  input wire i_all_columns_float,
  input wire i_all_columns_high,
  input wire i_post_pwm_float,
  input wire [1:0] i_phase_one_level,
  input wire [1:0] i_phase_two_level,
  input wire i_gray_zero,
  input wire i_pwm_on,
  output reg [1:0] o_level
);

  // Overrides first, then zero gray, then the selected phase level
  always @* begin
    o_level = `CDP_LVL_LOW;
    if (i_all_columns_float) begin
      o_level = `CDP_LVL_HIZ;
    end else if (i_all_columns_high) begin
      o_level = `CDP_LVL_HIGH;
    end else begin
      case (i_phase)
        `CDP_PH_ONE: begin
          // Dark column held low whatever level is chosen
          if (i_gray_zero) o_level = `CDP_LVL_LOW;
          else o_level = i_phase_one_level;
        end
        `CDP_PH_TWO: begin
          if (i_gray_zero) o_level = `CDP_LVL_LOW;
          else o_level = i_phase_two_level;
        end
        `CDP_PH_DRIVE: begin
          if (i_pwm_on) o_level = `CDP_LVL_CURRENT;
          else if (i_post_pwm_float) o_level = `CDP_LVL_HIZ;
          else o_level = `CDP_LVL_LOW;
        end
        default: begin
          o_level = `CDP_LVL_LOW;
        end
      endcase
    end
  end

endmodule // cdp_column_cell

// [logic/cdp_phase_ctrl.v]
// Column drive phase control: command decode, row scan sequencer,
// per-column level selection and the line-sync output.
// Assumes commands and gray data are synchronous to i_clk_sys.
`timescale 1ns/100ps
`include "cdp_consts.vh"

// How it works
// - After PWM, column low, or float if allowed
// - Line sync low during pulse, or float
// - All-float bit floats every column always
// - All-high bit ties columns to high rail
// - Phase one lasts length field plus one
// - Phase two lasts length field plus one
// - Phase one level from its two-bit field
// - Phase two level from its two-bit field
// - Phase levels only when overrides are clear
// - Zero gray forces low in phase one
// - Zero gray forces low in phase two
module cdp_phase_ctrl #(
  parameter NCOL = 8,
  parameter GW = 4,
  parameter DRV_W = 8,
  parameter DRIVE_CYCLES = `CDP_DRIVE_CYCLES,
  parameter ROWS = `CDP_ROWS
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_cmd_valid,
  input wire [15:0] i_cmd_word,
  input wire [GW*NCOL-1:0] i_gray_data,
  output reg [2*NCOL-1:0] o_col_level,
  output reg [1:0] o_phase,
  output reg o_row_start,
  output reg [6:0] o_row_index,
  output reg o_line_sync_out,
  output reg o_line_sync_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // True when a phase counter has reached the length field value
  function phase_done;
    input [5:0] cnt;
    input [5:0] len;
    begin
      phase_done = (cnt >= len);
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  reg [7:0] column_output_override; // Global override and float bits
  reg [7:0] setup_phase_one_config; // Phase one level and length
  reg [7:0] setup_phase_two_config; // Phase two level and length

  wire post_pwm_float;
  wire line_sync_float;
  wire all_columns_float;
  wire all_columns_high;
  wire overrides_clear;
  wire [5:0] phase_one_length;
  wire [5:0] phase_two_length;
  wire [1:0] phase_one_level;
  wire [1:0] phase_two_level;

  assign post_pwm_float = column_output_override[`CDP_BIT_POST_PWM_FLOAT];
  assign line_sync_float = column_output_override[`CDP_BIT_LINE_SYNC_FLOAT];
  assign all_columns_float = column_output_override[`CDP_BIT_ALL_FLOAT];
  assign all_columns_high = column_output_override[`CDP_BIT_ALL_HIGH];
  assign overrides_clear = ~all_columns_float & ~all_columns_high;
  assign phase_one_length =
    setup_phase_one_config[`CDP_LEN_MSB:`CDP_LEN_LSB];
  assign phase_two_length =
    setup_phase_two_config[`CDP_LEN_MSB:`CDP_LEN_LSB];
  assign phase_one_level =
    setup_phase_one_config[`CDP_LVL_MSB:`CDP_LVL_LSB];
  assign phase_two_level =
    setup_phase_two_config[`CDP_LVL_MSB:`CDP_LVL_LSB];

  // Command decode: only the addressed register takes the data byte
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      column_output_override <= `CDP_RST_OVERRIDE;
      setup_phase_one_config <= `CDP_RST_PH1;
      setup_phase_two_config <= `CDP_RST_PH2;
    end else if (i_cmd_valid) begin
      case (i_cmd_word[15:8])
        `CDP_ADDR_OVERRIDE: begin
          column_output_override <= i_cmd_word[7:0];
        end
        `CDP_ADDR_PH1: begin
          setup_phase_one_config <= i_cmd_word[7:0];
        end
        `CDP_ADDR_PH2: begin
          setup_phase_two_config <= i_cmd_word[7:0];
        end
        default: begin
          // Other command codes belong to other blocks
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Row scan sequencer
  // ----------------------------------------------------------------

  localparam [DRV_W-1:0] DRV_LAST = DRIVE_CYCLES - 1;
  localparam [6:0] ROW_LAST = ROWS - 1;
  localparam [5:0] SYNC_LAST = `CDP_SYNC_CYCLES - 1;

  reg [1:0] phase; // Current phase of the row
  reg [5:0] set_cnt; // Cycle count within a setup phase
  reg [DRV_W-1:0] drv_cnt; // Cycle count within the drive period
  reg [6:0] row; // Row being scanned
  reg [GW*NCOL-1:0] gray_row; // Gray data held for the row
  reg [1:0] next_phase;
  reg row_end;

  // Phase advance: lengths are field plus one cycles
  always @* begin
    next_phase = phase;
    row_end = 1'b0;
    case (phase)
      `CDP_PH_ONE: begin
        if (phase_done(set_cnt, phase_one_length))
          next_phase = `CDP_PH_TWO;
      end
      `CDP_PH_TWO: begin
        if (phase_done(set_cnt, phase_two_length))
          next_phase = `CDP_PH_DRIVE;
      end
      `CDP_PH_DRIVE: begin
        if (drv_cnt >= DRV_LAST) begin
          next_phase = `CDP_PH_ONE;
          row_end = 1'b1;
        end
      end
      default: begin
        next_phase = `CDP_PH_ONE;
      end
    endcase
  end

  // Counters, row index and gray capture at each row start
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase <= `CDP_PH_ONE;
      set_cnt <= 6'h00;
      drv_cnt <= {DRV_W{1'b0}};
      row <= 7'h00;
      gray_row <= {GW*NCOL{1'b0}};
    end else begin
      phase <= next_phase;
      // Counters restart whenever the phase changes
      if (next_phase != phase) begin
        set_cnt <= 6'h00;
        drv_cnt <= {DRV_W{1'b0}};
      end else if (phase == `CDP_PH_DRIVE) begin
        drv_cnt <= drv_cnt + 1'b1;
      end else begin
        set_cnt <= set_cnt + 1'b1;
      end
      if (row_end) begin
        // Scanning carries on whatever the overrides say
        if (row >= ROW_LAST) row <= 7'h00;
        else row <= row + 1'b1;
        gray_row <= i_gray_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Column level selection
  // ----------------------------------------------------------------

  wire [2*NCOL-1:0] next_col_level;

  genvar gi;
  generate
    for (gi = 0; gi < NCOL; gi = gi + 1) begin : g_col
      wire [GW-1:0] gray;
      wire pwm_on;
      assign gray = gray_row[gi*GW +: GW];
      // PWM current flows while the drive count is below the gray value,
      // so a zero gray value never sources current
      assign pwm_on = ({{GW{1'b0}}, drv_cnt} < {{DRV_W{1'b0}}, gray});
      cdp_column_cell u_cell (
        .i_phase(phase),
        .i_all_columns_float(all_columns_float),
        .i_all_columns_high(all_columns_high),
        .i_post_pwm_float(post_pwm_float),
        .i_phase_one_level(phase_one_level),
        .i_phase_two_level(phase_two_level),
        .i_gray_zero(gray == {GW{1'b0}}),
        .i_pwm_on(pwm_on),
        .o_level(next_col_level[gi*2 +: 2])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------

  wire sync_active;
  assign sync_active = (phase == `CDP_PH_ONE) && (set_cnt <= SYNC_LAST);

  // Column levels, phase, row marker and the line-sync pin
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_col_level <= {2*NCOL{1'b0}};
      o_phase <= `CDP_PH_ONE;
      o_row_start <= 1'b0;
      o_row_index <= 7'h00;
      o_line_sync_out <= 1'b1;
      o_line_sync_oe <= 1'b1;
    end else begin
      o_col_level <= next_col_level;
      o_phase <= phase;
      o_row_start <= (phase == `CDP_PH_ONE) && (set_cnt == 6'h00);
      o_row_index <= row;
      if (sync_active) begin
        // Pulse: low rail, or released when floating is allowed
        o_line_sync_out <= 1'b0;
        o_line_sync_oe <= ~(line_sync_float & overrides_clear);
      end else begin
        // Outside the pulse the output idles high and driven
        o_line_sync_out <= 1'b1;
        o_line_sync_oe <= 1'b1;
      end
    end
  end

endmodule // cdp_phase_ctrl

// [verification/cdp_panel_model.sv]
// Panel column model: counts current-sourcing cycles of each column per row.
// Assumes levels arrive registered and row_start marks a new row.
`timescale 1ns/100ps
module cdp_panel_model (
  input wire i_clk_sys,
  input wire i_row_start,
  input wire [15:0] i_col_level,
  output reg [39:0] o_lit
);
  reg [39:0] cnt = 40'h0; // Running current count, 5 bits a column
  integer n;
  // Latch the last row's counts and restart at each row start
  always @(posedge i_clk_sys) begin
    for (n = 0; n < 8; n = n + 1) begin
      if (i_row_start) begin
        o_lit[5*n+:5] <= cnt[5*n+:5];
        cnt[5*n+:5] <= {4'h0, i_col_level[2*n+:2] == 2'h3};
      end else if (i_col_level[2*n+:2] == 2'h3) begin
        cnt[5*n+:5] <= cnt[5*n+:5] + 5'h01;
      end
    end
  end
endmodule // cdp_panel_model

// [verification/cdp_phase_ctrl_chk.sv]
// Port checker for the column drive phase control.
// Assumes registers are written only while the drive period shows.
`timescale 1ns/100ps
module cdp_chk #(
  parameter DRIVE_CYCLES = 16
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_cmd_valid,
  input wire [15:0] i_cmd_word,
  input wire [31:0] i_gray_data,
  input wire [15:0] o_col_level,
  input wire [1:0] o_phase,
  input wire o_row_start,
  input wire o_line_sync_out,
  input wire o_line_sync_oe
);
  reg [7:0] ovr, p1, p2; // Shadow registers
  reg [1:0] ph_q; // Phase of the previous sample
  reg [6:0] run; // Samples spent in ph_q
  reg seen; // A drive period has shown
  // Follow the command port and time each phase
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ovr <= 8'h00;
      p1 <= 8'h0f;
      p2 <= 8'h00;
      ph_q <= 2'h0;
      run <= 7'h00;
      seen <= 1'b0;
    end else begin
      if (i_cmd_valid && i_cmd_word[15:8] == 8'h1a) ovr <= i_cmd_word[7:0];
      if (i_cmd_valid && i_cmd_word[15:8] == 8'h1b) p1 <= i_cmd_word[7:0];
      if (i_cmd_valid && i_cmd_word[15:8] == 8'h1c) p2 <= i_cmd_word[7:0];
      ph_q <= o_phase;
      run <= (o_phase != ph_q) ? 7'h01 : run + 7'h01;
      if (o_phase == 2'h2) seen <= 1'b1;
    end
  end
  // Expected setup level of every column
  function [15:0] lv(input [1:0] l);
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1)
        lv[2*c+:2] = ovr[2] ? 2'h1 : ovr[3] ? 2'h2 :
          (i_gray_data[4*c+:4] == 4'h0) ? 2'h0 : l;
    end
  endfunction
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  AST_ALL_FLOAT: assert property (
    $past(ovr[2]) |-> o_col_level == 16'h5555)
    else $error("columns not floating");
  AST_ALL_HIGH: assert property (
    $past(ovr[3:2]) == 2'h2 |-> o_col_level == 16'haaaa)
    else $error("columns not high");
  AST_PH_ORDER: assert property (
    o_phase != ph_q |-> o_phase == ((ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1))
    else $error("phase order broken");
  AST_PH1_LEN: assert property (
    seen && ph_q == 2'h0 && o_phase == 2'h1 |->
    run == {1'b0, p1[5:0]} + 7'h01)
    else $error("phase one length wrong");
  AST_PH2_LEN: assert property (
    ph_q == 2'h1 && o_phase == 2'h2 |-> run == {1'b0, p2[5:0]} + 7'h01)
    else $error("phase two length wrong");
  AST_DRIVE_LEN: assert property (
    ph_q == 2'h2 && o_phase == 2'h0 |-> run == DRIVE_CYCLES && o_row_start)
    else $error("drive length wrong");
  AST_SETUP_LVL: assert property (
    seen && o_phase != 2'h2 |->
    o_col_level == lv(o_phase == 2'h0 ? p1[7:6] : p2[7:6]))
    else $error("setup level wrong");
  AST_POST_PWM: assert property (
    o_phase == 2'h2 && ph_q == 2'h2 && run == DRIVE_CYCLES - 1 |->
    o_col_level == ((ovr[2] | (ovr[0] & ~ovr[3])) ? 16'h5555 :
    ovr[3] ? 16'haaaa : 16'h0000))
    else $error("post level wrong");
  AST_SYNC_PULSE: assert property (
    o_row_start |-> (ovr[1] && ovr[3:2] == 2'h0) ?
    !o_line_sync_oe : (!o_line_sync_out && o_line_sync_oe))
    else $error("line sync pulse wrong");
  AST_SYNC_IDLE: assert property (
    !o_row_start |-> o_line_sync_out && o_line_sync_oe)
    else $error("line sync idle wrong");
endmodule // cdp_chk
bind cdp_phase_ctrl cdp_chk #(.DRIVE_CYCLES(DRIVE_CYCLES)) chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
  .i_cmd_word(i_cmd_word), .i_gray_data(i_gray_data),
  .o_col_level(o_col_level), .o_phase(o_phase), .o_row_start(o_row_start),
  .o_line_sync_out(o_line_sync_out), .o_line_sync_oe(o_line_sync_oe));

// [verification/tb.sv]
// Testbench of the column drive phase control with a panel model.
// Assumes default parameters and gray data held constant.
`timescale 1ns/100ps
module tb;
  reg i_clk_sys, i_rst, i_cmd_valid;
  reg [15:0] i_cmd_word;
  reg [31:0] i_gray_data;
  wire [15:0] o_col_level;
  wire [1:0] o_phase;
  wire [6:0] o_row_index;
  wire o_row_start, o_line_sync_out, o_line_sync_oe;
  wire [39:0] lit;
  integer mismatches, tests_run, n, a, b, k;
  reg [7:0] v;
  cdp_phase_ctrl uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word),
    .i_gray_data(i_gray_data), .o_col_level(o_col_level), .o_phase(o_phase),
    .o_row_start(o_row_start), .o_row_index(o_row_index),
    .o_line_sync_out(o_line_sync_out), .o_line_sync_oe(o_line_sync_oe));
  cdp_panel_model pm (.i_clk_sys(i_clk_sys), .i_row_start(o_row_start),
    .i_col_level(o_col_level), .o_lit(lit));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task cyc;
    begin
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Wait for the next row start, bounded
  task rs;
    begin
      k = 0;
      cyc;
      while (o_row_start !== 1'b1 && k < 300) begin
        cyc;
        k = k + 1;
      end
    end
  endtask
  // Write one command word while the drive period shows
  task wr(input [15:0] w);
    begin
      rs;
      while (o_phase !== 2'h2 && k < 300) begin
        cyc;
        k = k + 1;
      end
      i_cmd_word = w;
      i_cmd_valid = 1'b1;
      cyc;
      i_cmd_valid = 1'b0;
    end
  endtask
  // Count the samples of phase one and phase two of one row
  task meas;
    begin
      rs;
      a = 0;
      b = 0;
      while (o_phase === 2'h0 && a < 99) begin
        a = a + 1;
        cyc;
      end
      while (o_phase === 2'h1 && b < 99) begin
        b = b + 1;
        cyc;
      end
    end
  endtask
  function [15:0] ex(input [1:0] l);
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1)
        ex[2*c+:2] = (i_gray_data[4*c+:4] == 4'h0) ? 2'h0 : l;
    end
  endfunction
  task t_len;
    begin
      rs;
      chk("first row", 16'h0, o_col_level);
      meas;
      chk("ph1 reset", 16'd16, a[15:0]);
      chk("ph2 reset", 16'd1, b[15:0]);
      for (n = 0; n < 64; n = n + 21) begin
        wr({8'h1b, 2'h0, n[5:0]});
        wr({8'h1c, 2'h0, ~n[5:0]});
        meas;
        chk("ph1 len", n[15:0] + 16'd1, a[15:0]);
        chk("ph2 len", 16'd64 - n[15:0], b[15:0]);
      end
      wr(16'h1dff);
      meas;
      chk("ignored", 16'd64, a[15:0]);
      $display("test lengths done");
    end
  endtask
  task t_lvl;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        wr({8'h1b, n[1:0], 6'h02});
        wr({8'h1c, ~n[1:0], 6'h02});
        rs;
        chk("ph1 lvl", ex(n[1:0]), o_col_level);
        while (o_phase !== 2'h1 && k < 300) begin
          cyc;
          k = k + 1;
        end
        chk("ph2 lvl", ex(~n[1:0]), o_col_level);
      end
      $display("test levels done");
    end
  endtask
  task t_ovr;
    begin
      wr(16'h1b02);
      wr(16'h1c02);
      for (n = 0; n < 5; n = n + 1) begin
        v = (n == 0) ? 8'h04 : (n == 1) ? 8'h08 : (n == 2) ? 8'h0c :
          (n == 3) ? 8'h03 : 8'h00;
        wr({8'h1a, v});
        rs;
        chk("sync oe", {15'h0, ~(v[1] & ~v[3] & ~v[2])}, o_line_sync_oe);
        chk("sync out", 16'h0, o_line_sync_oe & o_line_sync_out);
        chk("setup", v[2] ? 16'h5555 : v[3] ? 16'haaaa : 16'h0,
          o_col_level);
        cyc;
        chk("sync idle", 16'h3, {o_line_sync_out, o_line_sync_oe});
        while (o_phase !== 2'h2 && k < 300) begin
          cyc;
          k = k + 1;
        end
        repeat (15) cyc;
        chk("post", (v[2] | (v[0] & ~v[3])) ? 16'h5555 : v[3] ? 16'haaaa :
          16'h0, o_col_level);
      end
      rs;
      rs;
      for (n = 0; n < 8; n = n + 1)
        chk("lit", {12'h0, i_gray_data[4*n+:4]}, {11'h0, lit[5*n+:5]});
      $display("test overrides done");
    end
  endtask
  // Row index steps by one at each row start and wraps after row 71
  task t_row;
    begin
      rs;
      v = {1'b0, o_row_index};
      for (n = 0; n < 73; n = n + 1) begin
        rs;
        v = (v == 8'h47) ? 8'h00 : v + 8'h01;
        chk("row index", {8'h00, v}, {9'h000, o_row_index});
      end
      $display("test rows done");
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    mismatches = 0;
    tests_run = 0;
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd_word = 16'h0;
    i_gray_data = 32'hf0a03015;
    repeat (3) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    t_len;
    t_lvl;
    t_ovr;
    t_row;
    results;
  end
endmodule // tb
